// *** rtl/line_if_pkg.sv ***
package line_if_pkg;

   localparam int CHANNELS_DEFAULT = 2;
   localparam int CODE_W = 3;

   // Register byte offsets
   localparam logic [7:0] GLOBAL_STATUS_OFFSET = 8'h00;
   localparam logic [7:0] CHAN_CFG_BASE = 8'h04;
   localparam logic [7:0] CHAN_STATUS_BASE = 8'h0c;

   // Channel configuration fields
   localparam int CFG_CODE_LSB = 0;
   localparam int CFG_SPARE_BIT = 3;
   localparam int CFG_CODER_BIT = 4;
   localparam int CFG_TX_SUB_BIT = 5;
   localparam int CFG_RX_SUB_BIT = 6;
   localparam int CFG_JA_LSB = 7;
   localparam int CFG_W = 9;
   localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;

   // Channel status fields
   localparam int ST_CODE_LSB = 0;
   localparam int ST_SLICE65_BIT = 3;
   localparam int ST_IMP_LSB = 4;
   localparam int ST_GAPPED_BIT = 6;
   localparam int ST_DUTY_BIT = 7;
   localparam int ST_CODER_BIT = 8;
   localparam int ST_BAD_CODE_BIT = 9;

   // Global status fields
   localparam int GS_HOST_BIT = 0;
   localparam int GS_E1_BIT = 1;
   localparam int GS_MISMATCH_BIT = 2;
   localparam int GS_REF1X_BIT = 3;

   localparam logic [CODE_W-1:0] CODE_E1_75 = 3'h0;
   localparam logic [CODE_W-1:0] CODE_E1_120 = 3'h1;
   localparam logic [CODE_W-1:0] CODE_UNUSED = 3'h7;

   localparam int B8ZS_WIN = 8;
   localparam int HDB3_WIN = 4;
   localparam logic [2:0] B8ZS_SUPPRESS = 3'h4;

   typedef enum logic [1:0] {JA_BYPASS = 2'b00, JA_RX = 2'b01, JA_TX = 2'b10, JA_RSVD = 2'b11} ja_route_t;
   typedef enum logic [1:0] {IMP_75 = 2'b00, IMP_120 = 2'b01, IMP_100 = 2'b10} impedance_t;
   typedef enum logic [1:0] {SYM_ZERO = 2'b00, SYM_MARK = 2'b01, SYM_BIPOLAR = 2'b10, SYM_VIOL = 2'b11} line_sym_t;

endpackage

// *** rtl/line_encoder.sv ***
`timescale 1ns/10ps
module line_encoder
   import line_if_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic zero_sub_en,
   input wire logic hdb3_sel,
   input wire logic data_in,
   output logic line_pos,
   output logic line_neg
);

   line_sym_t sym_ff [B8ZS_WIN];
   line_sym_t sh [B8ZS_WIN];
   logic last_neg_ff, odd_ff, nxt_neg, nxt_odd;

   // HDB3 taps earlier so the pulse parity is settled when a window is marked
   wire line_sym_t tap = hdb3_sel ? sym_ff[HDB3_WIN-1] : sym_ff[B8ZS_WIN-1];
   wire pulse = (tap != SYM_ZERO);
   wire is_viol = (tap == SYM_VIOL);

   always_comb begin
      nxt_neg = pulse ? (is_viol ? last_neg_ff : ~last_neg_ff) : last_neg_ff;
      nxt_odd = is_viol ? 1'b0 : (pulse ? ~odd_ff : odd_ff);
      sh[0] = data_in ? SYM_MARK : SYM_ZERO;
      for (int i = 1; i < B8ZS_WIN; i++) begin
         sh[i] = sym_ff[i-1];
      end
      if (zero_sub_en && !hdb3_sel && sh.and() with (item == SYM_ZERO)) begin
         sh[4] = SYM_VIOL;
         sh[3] = SYM_BIPOLAR;
         sh[1] = SYM_VIOL;
         sh[0] = SYM_BIPOLAR;
      end else if (zero_sub_en && hdb3_sel && sh[0] == SYM_ZERO && sh[1] == SYM_ZERO &&
                   sh[2] == SYM_ZERO && sh[3] == SYM_ZERO) begin
         sh[3] = nxt_odd ? SYM_ZERO : SYM_BIPOLAR;
         sh[0] = SYM_VIOL;
      end
   end

   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < B8ZS_WIN; i++) sym_ff[i] <= SYM_ZERO;
         last_neg_ff <= 1'b1;
         odd_ff <= 1'b0;
         line_pos <= 1'b0;
         line_neg <= 1'b0;
      end else begin
         sym_ff <= sh;
         last_neg_ff <= nxt_neg;
         odd_ff <= nxt_odd;
         line_pos <= pulse & ~nxt_neg;
         line_neg <= pulse & nxt_neg;
      end
   end

endmodule // line_encoder

// *** rtl/line_decoder.sv ***
`timescale 1ns/10ps
module line_decoder
   import line_if_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic zero_sub_en,
   input wire logic hdb3_sel,
   input wire logic line_pos,
   input wire logic line_neg,
   output logic data_out
);

   logic [HDB3_WIN-1:0] data_ff;
   logic [2:0] supp_ff;
   logic last_neg_ff, seen_ff;

   wire pulse = line_pos | line_neg;
   // Same polarity as the previous pulse marks a substituted zero block
   wire viol = pulse && seen_ff && (line_neg == last_neg_ff);
   wire drop = zero_sub_en && (viol || supp_ff != 3'h0);
   wire bit_in = pulse && !drop;
   wire clear_b = zero_sub_en && hdb3_sel && viol;
   wire start_supp = zero_sub_en && !hdb3_sel && viol && supp_ff == 3'h0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_ff <= '0;
         supp_ff <= 3'h0;
         last_neg_ff <= 1'b0;
         seen_ff <= 1'b0;
         data_out <= 1'b0;
      end else begin
         data_out <= data_ff[HDB3_WIN-1];
         data_ff <= {data_ff[HDB3_WIN-2] & ~clear_b, data_ff[HDB3_WIN-3:0], bit_in};
         supp_ff <= start_supp ? B8ZS_SUPPRESS : (supp_ff != 3'h0 ? supp_ff - 3'h1 : 3'h0);
         if (pulse) begin
            last_neg_ff <= line_neg;
            seen_ff <= 1'b1;
         end
      end
   end

endmodule // line_decoder

// *** rtl/t1e1_line_interface_control.sv ***
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
module t1e1_line_interface_control
   import line_if_pkg::*;
#(
   parameter int CHANNELS = CHANNELS_DEFAULT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic host_mode,
   input wire logic [CODE_W*CHANNELS-1:0] hw_line_config_code,
   input wire logic [CHANNELS-1:0] hw_coder_enable,
   input wire logic hw_zero_sub_select,
   input wire logic [1:0] hw_ja_route,
   input wire logic ref_rate_select,
   input wire logic [CHANNELS-1:0] ja_protect_active,
   input wire logic tx_line_clock,
   input wire logic [CHANNELS-1:0] tx_positive_rail,
   input wire logic [CHANNELS-1:0] tx_negative_rail,
   output logic [CHANNELS-1:0] tx_line_pos,
   output logic [CHANNELS-1:0] tx_line_neg,
   input wire logic rx_recovered_clock,
   input wire logic [CHANNELS-1:0] rx_line_pos,
   input wire logic [CHANNELS-1:0] rx_line_neg,
   output logic [CHANNELS-1:0] rx_positive_rail,
   output logic [CHANNELS-1:0] rx_negative_rail,
   output logic [CHANNELS-1:0] slicer_level_65,
   output logic [CODE_W*CHANNELS-1:0] pulse_shape_code,
   output logic [2*CHANNELS-1:0] source_impedance_sel,
   output logic [2*CHANNELS-1:0] ja_route_out,
   output logic [CHANNELS-1:0] gapped_clock_ok,
   output logic [CHANNELS-1:0] rx_duty_relaxed,
   output logic ref_rate_8x
);

   localparam int PIN_W = 1 + CODE_W*CHANNELS + CHANNELS + 1 + 2 + 1 + CHANNELS;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [PIN_W-1:0] pin_meta_ff, pin_sync_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
      end else begin
         pin_meta_ff <= {host_mode, hw_line_config_code, hw_coder_enable, hw_zero_sub_select,
                         hw_ja_route, ref_rate_select, ja_protect_active};
         pin_sync_ff <= pin_meta_ff;
      end
   end

   wire [CHANNELS-1:0] s_protect = pin_sync_ff[CHANNELS-1:0];
   wire s_ref_1x = pin_sync_ff[CHANNELS];
   wire [1:0] s_hw_ja = pin_sync_ff[CHANNELS+2:CHANNELS+1];
   wire s_hw_sub = pin_sync_ff[CHANNELS+3];
   wire [CHANNELS-1:0] s_hw_coder = pin_sync_ff[2*CHANNELS+3:CHANNELS+4];
   wire [CODE_W*CHANNELS-1:0] s_hw_code = pin_sync_ff[PIN_W-2:2*CHANNELS+4];
   wire s_host = pin_sync_ff[PIN_W-1];

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states

   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic [CFG_W-1:0] cfg_ff [CHANNELS];
   logic [31:0] status_word [CHANNELS];
   logic [31:0] global_word;
   logic [31:0] rd_mux;

   wire addr_phase = hsel && hready && htrans[1];
   wire [7:0] a_off = haddr[7:0];
   wire a_in_page = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);

   always_comb begin
      rd_mux = 32'h00000000;
      if (a_in_page && a_off == GLOBAL_STATUS_OFFSET) begin
         rd_mux = global_word;
      end
      for (int c = 0; c < CHANNELS; c++) begin
         if (a_in_page && a_off == CHAN_CFG_BASE + 8'(4*c)) begin
            // Forward a write still in its data phase
            rd_mux = (wr_pend_ff && wr_addr_ff == a_off) ? {23'h0, hwdata[CFG_W-1:0]} : {23'h0, cfg_ff[c]};
         end
         if (a_in_page && a_off == CHAN_STATUS_BASE + 8'(4*c)) begin
            rd_mux = status_word[c];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         hrdata <= 32'h00000000;
      end else begin
         wr_pend_ff <= addr_phase && hwrite && a_in_page;
         wr_addr_ff <= a_off;
         if (addr_phase && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // Per-channel configuration and derived controls

   logic [CODE_W-1:0] eff_code [CHANNELS];
   logic [CHANNELS-1:0] eff_coder, eff_tx_sub, eff_rx_sub, bad_code;
   logic [1:0] eff_ja [CHANNELS];

   // Rate follows channel 0; a disagreeing channel is flagged and forced to match
   wire rate_e1 = (eff_code[0] == CODE_E1_75) || (eff_code[0] == CODE_E1_120);
   logic rate_mismatch;

   always_comb begin
      rate_mismatch = 1'b0;
      for (int c = 1; c < CHANNELS; c++) begin
         if (((eff_code[c] == CODE_E1_75) || (eff_code[c] == CODE_E1_120)) != rate_e1) begin
            rate_mismatch = 1'b1;
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_chan
         wire [CODE_W-1:0] raw_code = s_host ? cfg_ff[g][CFG_CODE_LSB +: CODE_W]
                                             : s_hw_code[CODE_W*g +: CODE_W];
         wire raw_bad = (raw_code == CODE_UNUSED) || (s_host && cfg_ff[g][CFG_SPARE_BIT]);
         wire is_e1 = (eff_code[g] == CODE_E1_75) || (eff_code[g] == CODE_E1_120);
         wire lane_mismatch = (g != 0) && (is_e1 != rate_e1);
         wire [CODE_W-1:0] final_code = lane_mismatch ? eff_code[0] : eff_code[g];
         wire final_e1 = (final_code == CODE_E1_75) || (final_code == CODE_E1_120);
         wire [1:0] imp = !final_e1 ? IMP_100 : (final_code == CODE_E1_120 ? IMP_120 : IMP_75);

         always_comb begin
            eff_code[g] = raw_bad ? CODE_E1_75 : raw_code;
            bad_code[g] = raw_bad;
            // Pin mode offers one shared substitution choice and one routing choice
            eff_coder[g] = s_host ? cfg_ff[g][CFG_CODER_BIT] : s_hw_coder[g];
            eff_tx_sub[g] = s_host ? cfg_ff[g][CFG_TX_SUB_BIT] : s_hw_sub;
            eff_rx_sub[g] = s_host ? cfg_ff[g][CFG_RX_SUB_BIT] : s_hw_sub;
            eff_ja[g] = s_host ? cfg_ff[g][CFG_JA_LSB +: 2] : s_hw_ja;
         end

         wire wr_hit = wr_pend_ff && (wr_addr_ff == CHAN_CFG_BASE + 8'(4*g));

         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cfg_ff[g] <= CFG_RESET;
               pulse_shape_code[CODE_W*g +: CODE_W] <= CODE_E1_75;
               slicer_level_65[g] <= 1'b0;
               source_impedance_sel[2*g +: 2] <= IMP_75;
               ja_route_out[2*g +: 2] <= JA_BYPASS;
               gapped_clock_ok[g] <= 1'b0;
               rx_duty_relaxed[g] <= 1'b0;
            end else begin
               if (wr_hit) begin
                  cfg_ff[g] <= hwdata[CFG_W-1:0];
               end
               pulse_shape_code[CODE_W*g +: CODE_W] <= final_code;
               slicer_level_65[g] <= !final_e1;
               source_impedance_sel[2*g +: 2] <= imp;
               ja_route_out[2*g +: 2] <= eff_ja[g];
               gapped_clock_ok[g] <= (eff_ja[g] == JA_TX);
               rx_duty_relaxed[g] <= (eff_ja[g] == JA_RX) && s_protect[g];
            end
         end

         assign status_word[g] = {22'h0, bad_code[g], eff_coder[g], rx_duty_relaxed[g], gapped_clock_ok[g],
                                  source_impedance_sel[2*g +: 2], slicer_level_65[g],
                                  pulse_shape_code[CODE_W*g +: CODE_W]};

         ////////////////////////////////////////////////////////////////
         // Transmit side, falling edge of the transmit clock

         logic [2:0] tx_meta_ff, tx_sync_ff;
         logic tx_pos_cap_ff, tx_neg_cap_ff;
         logic enc_pos, enc_neg;

         // Static controls crossing as levels; changes settle within two clocks
         always_ff @(negedge tx_line_clock or negedge hresetn) begin
            if (!hresetn) begin
               tx_meta_ff <= 3'h0;
               tx_sync_ff <= 3'h0;
               tx_pos_cap_ff <= 1'b0;
               tx_neg_cap_ff <= 1'b0;
               tx_line_pos[g] <= 1'b0;
               tx_line_neg[g] <= 1'b0;
            end else begin
               tx_meta_ff <= {eff_coder[g], eff_tx_sub[g], rate_e1};
               tx_sync_ff <= tx_meta_ff;
               tx_pos_cap_ff <= tx_positive_rail[g];
               tx_neg_cap_ff <= tx_negative_rail[g];
               tx_line_pos[g] <= tx_sync_ff[2] ? enc_pos : tx_pos_cap_ff;
               tx_line_neg[g] <= tx_sync_ff[2] ? enc_neg : tx_neg_cap_ff;
            end
         end

         line_encoder u_enc (
            .clk(tx_line_clock),
            .rst_n(hresetn),
            .zero_sub_en(tx_sync_ff[1]),
            .hdb3_sel(tx_sync_ff[0]),
            .data_in(tx_pos_cap_ff),
            .line_pos(enc_pos),
            .line_neg(enc_neg)
         );

         ////////////////////////////////////////////////////////////////
         // Receive side, recovered clock

         logic [2:0] rx_meta_ff, rx_sync_ff;
         logic rx_pos_ff, rx_neg_ff;
         logic dec_data;

         always_ff @(posedge rx_recovered_clock or negedge hresetn) begin
            if (!hresetn) begin
               rx_meta_ff <= 3'h0;
               rx_sync_ff <= 3'h0;
               rx_pos_ff <= 1'b0;
               rx_neg_ff <= 1'b0;
            end else begin
               rx_meta_ff <= {eff_coder[g], eff_rx_sub[g], rate_e1};
               rx_sync_ff <= rx_meta_ff;
               rx_pos_ff <= rx_line_pos[g];
               rx_neg_ff <= rx_line_neg[g];
            end
         end

         line_decoder u_dec (
            .clk(rx_recovered_clock),
            .rst_n(hresetn),
            .zero_sub_en(rx_sync_ff[1]),
            .hdb3_sel(rx_sync_ff[0]),
            .line_pos(rx_pos_ff),
            .line_neg(rx_neg_ff),
            .data_out(dec_data)
         );

         // Launch on the falling edge so a rising-edge sampler sees settled data
         always_ff @(negedge rx_recovered_clock or negedge hresetn) begin
            if (!hresetn) begin
               rx_positive_rail[g] <= 1'b0;
               rx_negative_rail[g] <= 1'b0;
            end else begin
               rx_positive_rail[g] <= rx_sync_ff[2] ? dec_data : rx_pos_ff;
               rx_negative_rail[g] <= rx_sync_ff[2] ? 1'b0 : rx_neg_ff;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Global status and reference rate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_rate_8x <= 1'b0;
      end else begin
         ref_rate_8x <= !s_ref_1x;
      end
   end

   assign global_word = {28'h0, s_ref_1x, rate_mismatch, rate_e1, s_host};

endmodule // t1e1_line_interface_control

// *** testbench/t1e1_line_interface_control_checker.sv ***
`timescale 1ns/10ps
module line_if_checker
   import line_if_pkg::*;
#(
   parameter int CHANNELS = CHANNELS_DEFAULT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic ref_rate_select,
   input wire logic [CHANNELS-1:0] tx_line_pos,
   input wire logic [CHANNELS-1:0] tx_line_neg,
   input wire logic [CHANNELS-1:0] slicer_level_65,
   input wire logic [CODE_W*CHANNELS-1:0] pulse_shape_code,
   input wire logic [2*CHANNELS-1:0] source_impedance_sel,
   input wire logic [2*CHANNELS-1:0] ja_route_out,
   input wire logic [CHANNELS-1:0] gapped_clock_ok,
   input wire logic [CHANNELS-1:0] rx_duty_relaxed,
   input wire logic ref_rate_8x
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire [2:0] code0 = pulse_shape_code[2:0];
   wire [2:0] code1 = pulse_shape_code[5:3];
   wire rd_taken = hsel && hready && htrans[1] && !hwrite;
   sequence quiet_cfg;
      $stable(pulse_shape_code)[*2];
   endsequence
   sequence quiet_ref;
      $stable(ref_rate_select)[*5];
   endsequence
   ////////////////////////////////////////////////////////////////
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   rdata_hold_a: assert property (!rd_taken |=> $stable(hrdata))
      else $error("read data moved without a read");
   slice_level_a: assert property (slicer_level_65[0] == (code0 inside {[3'h2:3'h6]}))
      else $error("slicer level does not follow code");
   impedance_map_a: assert property (source_impedance_sel[1:0] ==
      (code0 == 3'h0 ? 2'h0 : (code0 == 3'h1 ? 2'h1 : 2'h2))) else $error("impedance does not follow code");
   unused_code_a: assert property (code0 != 3'h7 && code1 != 3'h7)
      else $error("unused code applied");
   same_rate_a: assert property (quiet_cfg |-> (code0 < 3'h2) == (code1 < 3'h2))
      else $error("channels at different rates");
   gapped_route_a: assert property (gapped_clock_ok ==
      {ja_route_out[3:2] == 2'b10, ja_route_out[1:0] == 2'b10}) else $error("gapped flag without tx route");
   duty_route_a: assert property (rx_duty_relaxed[0] |-> ja_route_out[1:0] == 2'b01)
      else $error("duty relaxed without rx route");
   ref_rate_a: assert property (quiet_ref |-> ref_rate_8x == !ref_rate_select)
      else $error("reference rate flag wrong");
   one_polarity_a: assert property (!(tx_line_pos[0] && tx_line_neg[0]))
      else $error("both line rails driven");
endmodule // line_if_checker

bind t1e1_line_interface_control line_if_checker #(.CHANNELS(CHANNELS)) chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_rate_select(ref_rate_select),
   .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg), .slicer_level_65(slicer_level_65),
   .pulse_shape_code(pulse_shape_code), .source_impedance_sel(source_impedance_sel),
   .ja_route_out(ja_route_out), .gapped_clock_ok(gapped_clock_ok), .rx_duty_relaxed(rx_duty_relaxed),
   .ref_rate_8x(ref_rate_8x)
);

// *** testbench/framer_partner.sv ***
`timescale 1ns/10ps
module framer_partner (
   input wire logic run,
   input wire logic coder,
   input wire logic [63:0] pattern,
   output logic link_clk,
   output logic [1:0] tx_pos,
   output logic [1:0] tx_neg,
   input wire logic [1:0] rx_pos,
   input wire logic [1:0] rx_neg,
   output logic [63:0] sent_pos,
   output logic [63:0] sent_neg,
   output logic [63:0] got_pos,
   output logic [63:0] got_neg
);
   logic [5:0] idx = 6'h00;
   wire p = pattern[idx];
   // A framer never drives both rails; coder mode is unipolar
   wire n = !coder && !p && pattern[idx + 6'h07];
   // Clock rests low between bursts, phase unrelated to the bus clock
   initial begin
      link_clk = 1'b0;
      #37;
      forever begin
         #80;
         link_clk = run ? ~link_clk : 1'b0;
      end
   end
   // Launch at rise so data is settled at the falling capture edge
   always @(posedge link_clk) begin
      tx_pos <= {2{p}};
      tx_neg <= {2{n}};
      sent_pos <= {sent_pos[62:0], p};
      sent_neg <= {sent_neg[62:0], n};
      idx <= idx + 6'h01;
   end
   always @(posedge link_clk) begin
      got_pos <= {got_pos[62:0], rx_pos[0]};
      got_neg <= {got_neg[62:0], rx_neg[0]};
   end
endmodule // framer_partner

// *** testbench/t1e1_line_interface_control_tb.sv ***
`timescale 1ns/10ps
module t1e1_line_interface_control_tb;
   logic hclk, hresetn, hsel, hwrite, host_mode, zsub, ref_sel, run, coder, exp_sl;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0] htrans, hw_route, hw_coder, protect, exp_imp;
   logic [2:0] hsize;
   logic [5:0] hw_code;
   logic [63:0] pattern;
   logic [8:0] cfgs [5] = '{9'h002, 9'h072, 9'h070, 9'h012, 9'h032};
   logic [4:0] expm = 5'b01111;
   wire hreadyout, hresp, link_clk, ref_8x;
   wire [31:0] hrdata;
   wire [1:0] txp, txn, tx_lp, tx_ln, rxp, rxn, slicer, gapped, duty;
   wire [5:0] shape;
   wire [3:0] imp, route;
   wire [63:0] sent_pos, sent_neg, got_pos, got_neg;
   int fail_count, tests_run;

   t1e1_line_interface_control #(.CHANNELS(2)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .host_mode(host_mode), .hw_line_config_code(hw_code), .hw_coder_enable(hw_coder),
      .hw_zero_sub_select(zsub), .hw_ja_route(hw_route), .ref_rate_select(ref_sel),
      .ja_protect_active(protect), .tx_line_clock(link_clk), .tx_positive_rail(txp),
      .tx_negative_rail(txn), .tx_line_pos(tx_lp), .tx_line_neg(tx_ln), .rx_recovered_clock(link_clk),
      .rx_line_pos(tx_lp), .rx_line_neg(tx_ln), .rx_positive_rail(rxp), .rx_negative_rail(rxn),
      .slicer_level_65(slicer), .pulse_shape_code(shape), .source_impedance_sel(imp),
      .ja_route_out(route), .gapped_clock_ok(gapped), .rx_duty_relaxed(duty), .ref_rate_8x(ref_8x));

   framer_partner partner (
      .run(run), .coder(coder), .pattern(pattern), .link_clk(link_clk), .tx_pos(txp), .tx_neg(txn),
      .rx_pos(rxp), .rx_neg(rxn), .sent_pos(sent_pos), .sent_neg(sent_neg), .got_pos(got_pos),
      .got_neg(got_neg));

   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Host drops select and request at the address edge, then waits one more edge for the answer
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   // Recent received bits must equal the sent stream at some lag
   function automatic logic lag_match(input logic [63:0] s, input logic [63:0] g);
      for (int l = 0; l < 32; l++) if (g[23:0] === s[l +: 24]) return 1'b1;
      return 1'b0;
   endfunction

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      give_verdict();
   end

   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, run, coder, zsub, protect, hw_coder, host_mode} = '0;
      hsize = 3'h2;
      hresetn = 1'b0;
      hw_code = 6'h32;
      hw_route = 2'h2;
      ref_sel = 1'b1;
      // Every 24-bit window holds a full zero byte, so substitution always fires
      pattern = 64'hb7005a00c300e900;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, 8'h04, 32'h0);
      check(rd, 32'h0);
      repeat (6) @(posedge hclk);
      check(32'(shape), 32'h32);
      check(32'(slicer), 32'h3);
      check(32'(imp), 32'ha);
      check(32'(gapped), 32'h3);
      check(32'(ref_8x), 32'h0);
      hw_route <= 2'h1;
      protect <= 2'h2;
      ref_sel <= 1'b0;
      hw_code <= 6'h08;
      repeat (6) @(posedge hclk);
      check(32'(duty), 32'h2);
      check(32'(ref_8x), 32'h1);
      check(32'(slicer), 32'h0);
      check(32'(imp), 32'h4);
      host_mode <= 1'b1;
      for (int c = 0; c < 7; c++) begin
         bus(1'b1, 8'h04, 32'(c));
         bus(1'b1, 8'h08, 32'(c));
         repeat (4) @(posedge hclk);
         exp_imp = c == 0 ? 2'h0 : (c == 1 ? 2'h1 : 2'h2);
         exp_sl = c > 1;
         bus(1'b0, 8'h0c, 32'h0);
         check(32'(rd[5:0]), 32'({exp_imp, exp_sl, 3'(c)}));
         check(32'(slicer), 32'({2{exp_sl}}));
         check(32'(imp), 32'({2{exp_imp}}));
      end
      bus(1'b1, 8'h04, 32'h0);
      bus(1'b1, 8'h08, 32'h7);
      repeat (4) @(posedge hclk);
      bus(1'b0, 8'h10, 32'h0);
      check(32'(rd[9]), 32'h1);
      check(32'(shape[5:3]), 32'h0);
      bus(1'b1, 8'h08, 32'h8);
      bus(1'b0, 8'h10, 32'h0);
      check(32'(rd[9]), 32'h1);
      bus(1'b1, 8'h04, 32'h102);
      bus(1'b1, 8'h08, 32'h080);
      protect <= 2'h3;
      repeat (6) @(posedge hclk);
      bus(1'b0, 8'h00, 32'h0);
      check(32'(rd[3:0]), 32'h5);
      check(32'(shape[5:3]), 32'h2);
      check(32'(route), 32'h6);
      check(32'(gapped), 32'h1);
      check(32'(duty), 32'h2);
      bus(1'b0, 8'h04, 32'h0);
      check(rd, 32'h102);
      bus(1'b1, 8'h0c, 32'hffff);
      bus(1'b0, 8'h0c, 32'h0);
      check(rd, 32'h6a);
      bus(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, 8'h04, 32'(cfgs[i]));
         bus(1'b1, 8'h08, 32'(cfgs[i]));
         coder <= cfgs[i][4];
         run <= 1'b1;
         repeat (500) @(posedge hclk);
         run <= 1'b0;
         repeat (10) @(posedge hclk);
         check(32'(lag_match(sent_pos, got_pos)), 32'(expm[i]));
         if (cfgs[i][4]) check(32'(got_neg[23:0]), 32'h0);
         else check(32'(lag_match(sent_neg, got_neg)), 32'h1);
      end
      give_verdict();
   end
endmodule // t1e1_line_interface_control_tb
